// >>> ivpl_top.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ivpl_consts.svh"

// Overview of operation
// - smaller vector number wins; top entry wins
// - pair first byte high, next byte low
// - flag sets on event whatever its enable
// - request only while flag's enable is 1
// - mask set, then winning vector presented
// - time-of-day uses vector 29, three enables
// - highest priority served first after unmask
// - global mask comes up set after reset
module ivpl_top
	import ivpl_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	// peripheral events, one per vector 12..32; bit 17 (vector 29) unused (same clock)
	input  wire logic [20:0] SRC_EVENT,
	input  wire logic        QUARTER_SECOND_EVENT,
	input  wire logic        ONE_SECOND_EVENT,
	input  wire logic        ALARM_MATCH_EVENT,
	// processor core side
	input  wire logic        CORE_MASK_SET,
	input  wire logic        CORE_MASK_CLR,
	input  wire logic        CORE_FETCH_RD,
	input  wire logic [15:0] CORE_FETCH_ADDR,
	output logic             CORE_IRQ_REQ,
	output logic             GLOBAL_MASK,
	output logic [5:0]       VECTOR_NUM,
	output logic [7:0]       CORE_FETCH_DATA,
	output logic             CORE_FETCH_VALID,
	// axi4-lite slave
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);

	logic [1:0]    rst_sync;
	logic          rst_n;
	ivpl_flags_t   flags;
	ivpl_flags_t   enable;
	ivpl_flags_t   events;
	ivpl_flags_t   clr_pulse;
	logic [20:0]   vec_req;
	ivpl_vec_t     next_winner;
	logic          any_req;
	ivpl_addr_t    isr_table [NUM_VEC];
	logic          aw_held;
	logic          w_held;
	logic [11:0]   aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          do_write;
	logic [31:0]   next_rdata;
	logic          rd_hit;

	// vector pair address; the last entry breaks the stride
	function automatic ivpl_addr_t pair_addr(input ivpl_vec_t n);
		pair_addr = (n == `IVPL_VEC_LAST) ? `IVPL_PAIR_LAST
			: `IVPL_PAIR_TOP - {9'h000, n, 1'b0};
	endfunction : pair_addr
	// table slot of a word offset, NUM_VEC when outside
	function automatic logic [4:0] table_slot(input logic [11:0] a);
		logic [11:0] d;
		d = a - `IVPL_OFS_TABLE;
		table_slot = (a >= `IVPL_OFS_TABLE && d[11:2] < NUM_VEC
			&& a[1:0] == 2'h0) ? d[6:2] : 5'(NUM_VEC);
	endfunction : table_slot
	// reset release through two flops
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];
	// event vector in flag-bit layout
	always_comb begin
		events = {ALARM_MATCH_EVENT, ONE_SECOND_EVENT, SRC_EVENT};
		events[`IVPL_BIT_QSEC] = QUARTER_SECOND_EVENT;
	end
	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr_pulse) | events;
		end
	end
	// per-vector request; time-of-day ors its three gated flags
	always_comb begin
		vec_req = flags[20:0] & enable[20:0];
		vec_req[`IVPL_BIT_QSEC] = |(flags & enable & ((ivpl_flags_t'(1)
			<< `IVPL_BIT_QSEC) | (ivpl_flags_t'(1) << `IVPL_BIT_SEC)
			| (ivpl_flags_t'(1) << `IVPL_BIT_MATCH)));
	end
	// priority pick: loop runs downward so the smallest number is last
	always_comb begin
		next_winner = '0;
		any_req = |vec_req;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (vec_req[i]) begin
				next_winner = `IVPL_VEC_FIRST + 6'(i);
			end
		end
	end
	// request line toward the core doubles as the interrupt output
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			CORE_IRQ_REQ <= 1'b0;
		end else begin
			CORE_IRQ_REQ <= any_req;
		end
	end

	// global mask; set wins so no nesting slips through
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			GLOBAL_MASK <= `IVPL_RST_MASK;
		end else if (CORE_MASK_SET) begin
			GLOBAL_MASK <= 1'b1;
		end else if (CORE_MASK_CLR || (do_write && aw_addr ==
			`IVPL_OFS_MASK && w_strb[0] && w_data[0])) begin
			GLOBAL_MASK <= 1'b0;
		end
	end

	// winner frozen when the core sets the mask after stacking
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			VECTOR_NUM <= '0;
		end else if (CORE_MASK_SET && !GLOBAL_MASK) begin
			VECTOR_NUM <= next_winner;
		end
	end

	// vector fetch: first byte of the pair high, second low
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			CORE_FETCH_DATA <= '0;
			CORE_FETCH_VALID <= 1'b0;
		end else begin
			CORE_FETCH_VALID <= CORE_FETCH_RD;
			CORE_FETCH_DATA <= 8'h00;
			if (CORE_FETCH_RD) begin
				for (int i = 0; i < NUM_VEC; i++) begin
					if ({CORE_FETCH_ADDR[15:1], 1'b0} == pair_addr(
						`IVPL_VEC_FIRST + 6'(i))) begin
						CORE_FETCH_DATA <= CORE_FETCH_ADDR[0]
							? isr_table[i][7:0] : isr_table[i][15:8];
					end
				end
			end
		end
	end
	// write channel: address and data caught in either order
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end
	assign do_write = aw_held && w_held && !S_AXI_BVALID;

	// ready while nothing is held; response after the write lands
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `IVPL_RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY);
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (aw_addr == `IVPL_OFS_ENABLE
					|| aw_addr == `IVPL_OFS_CLEAR
					|| aw_addr == `IVPL_OFS_MASK
					|| table_slot(aw_addr) != 5'(NUM_VEC))
					? `IVPL_RESP_OKAY : `IVPL_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// clear register is write-one-to-clear, lasts one cycle
	always_comb begin
		clr_pulse = '0;
		if (do_write && aw_addr == `IVPL_OFS_CLEAR) begin
			clr_pulse = w_data[NUM_FLAG-1:0];
		end
	end

	// enable register and vector table, byte lanes honoured
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			enable <= `IVPL_RST_ENABLE;
			for (int i = 0; i < NUM_VEC; i++) begin
				isr_table[i] <= `IVPL_RST_ISR;
			end
		end else if (do_write) begin
			for (int i = 0; i < NUM_FLAG; i++) begin
				if (aw_addr == `IVPL_OFS_ENABLE && w_strb[i/8]) begin
					enable[i] <= w_data[i];
				end
			end
			for (int i = 0; i < NUM_VEC; i++) begin
				if (table_slot(aw_addr) == 5'(i)) begin
					if (w_strb[0]) isr_table[i][7:0] <= w_data[7:0];
					if (w_strb[1]) isr_table[i][15:8] <= w_data[15:8];
				end
			end
		end
	end

	// read decode
	always_comb begin
		next_rdata = 32'h00000000;
		rd_hit = 1'b1;
		case (S_AXI_ARADDR)
			`IVPL_OFS_STATUS: next_rdata = {9'h000, flags};
			`IVPL_OFS_ENABLE: next_rdata = {9'h000, enable};
			`IVPL_OFS_CLEAR:  next_rdata = 32'h00000000;
			`IVPL_OFS_MASK:   next_rdata = {31'h00000000, GLOBAL_MASK};
			`IVPL_OFS_WINNER: next_rdata = {23'h000000, any_req, 2'h0,
				next_winner};
			default: begin
				if (table_slot(S_AXI_ARADDR) != 5'(NUM_VEC)) begin
					next_rdata = {16'h0000,
						isr_table[table_slot(S_AXI_ARADDR)]};
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	// read channel: one read in flight, answer one cycle later
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= `IVPL_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID
				&& !(S_AXI_ARVALID && S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= next_rdata;
				S_AXI_RRESP <= rd_hit ? `IVPL_RESP_OKAY : `IVPL_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule : ivpl_top
`default_nettype wire

// >>> ivpl_consts.svh
`ifndef IVPL_CONSTS_SVH
`define IVPL_CONSTS_SVH

// register byte offsets on the AXI4-Lite port
`define IVPL_OFS_STATUS  12'h000
`define IVPL_OFS_ENABLE  12'h004
`define IVPL_OFS_CLEAR   12'h008
`define IVPL_OFS_MASK    12'h00C
`define IVPL_OFS_WINNER  12'h010
`define IVPL_OFS_TABLE   12'h100
// vector numbering of the covered range
`define IVPL_VEC_FIRST   6'h0C
`define IVPL_VEC_LAST    6'h20
`define IVPL_VEC_TOD     6'h1D
`define IVPL_PAIR_TOD    16'hFFC4
`define IVPL_PAIR_LAST   16'hFF9E
`define IVPL_PAIR_TOP    16'hFFFE
// flag bit positions of the time-of-day unit
`define IVPL_BIT_QSEC    17
`define IVPL_BIT_SEC     21
`define IVPL_BIT_MATCH   22
// reset values and response codes
`define IVPL_RST_ENABLE  23'h000000
`define IVPL_RST_MASK    1'b1
`define IVPL_RST_ISR     16'h0000
`define IVPL_RESP_OKAY   2'h0
`define IVPL_RESP_SLVERR 2'h2

`endif

// >>> ivpl_pkg.sv
package ivpl_pkg;
	localparam int NUM_VEC  = 21;
	localparam int NUM_FLAG = 23;
	typedef logic [5:0]          ivpl_vec_t;
	typedef logic [NUM_FLAG-1:0] ivpl_flags_t;
	typedef logic [15:0]         ivpl_addr_t;
endpackage : ivpl_pkg

// >>> ivpl_props.sv
`timescale 1ns/100ps
`default_nettype none
module ivpl_props (
	// watched ports
	input wire logic       REF_CLK,
	input wire logic       RST_B,
	input wire logic       CORE_MASK_SET,
	input wire logic       CORE_FETCH_RD,
	input wire logic       CORE_IRQ_REQ,
	input wire logic       GLOBAL_MASK,
	input wire logic [5:0] VECTOR_NUM,
	input wire logic       CORE_FETCH_VALID
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	// entry step: core masks while unmasked with a request up
	sequence s_take;
		CORE_MASK_SET && !GLOBAL_MASK && CORE_IRQ_REQ;
	endsequence
	// fetch step: one vector byte asked
	sequence s_ask;
		CORE_FETCH_RD;
	endsequence
	chk_mask_up: assert property (s_take |=> GLOBAL_MASK)
		else $error("mask not set on entry");
	chk_vec_range: assert property (s_take |=>
		VECTOR_NUM >= 6'h0C && VECTOR_NUM <= 6'h20)
		else $error("winner outside vector range");
	chk_vec_hold: assert property (!$stable(VECTOR_NUM) |->
		$past(CORE_MASK_SET) && !$past(GLOBAL_MASK))
		else $error("vector changed without entry");
	chk_vec_keep: assert property (GLOBAL_MASK |=> $stable(VECTOR_NUM))
		else $error("vector moved while masked");
	chk_fetch_ans: assert property (s_ask |=> CORE_FETCH_VALID)
		else $error("fetch not answered");
	chk_fetch_cause: assert property (CORE_FETCH_VALID |->
		$past(CORE_FETCH_RD))
		else $error("fetch answer without request");
	chk_mask_src: assert property ($rose(GLOBAL_MASK) |->
		$past(CORE_MASK_SET))
		else $error("mask rose without entry");
	chk_mask_rst: assert property ($rose(RST_B) |-> GLOBAL_MASK[*2])
		else $error("mask clear after reset");
endmodule : ivpl_props
bind ivpl_top ivpl_props u_props (.REF_CLK, .RST_B, .CORE_MASK_SET,
	.CORE_FETCH_RD, .CORE_IRQ_REQ, .GLOBAL_MASK, .VECTOR_NUM,
	.CORE_FETCH_VALID);
`default_nettype wire

// >>> ivpl_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ivpl_core_model (
	// clock, reset, pacing
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [3:0]  lag,
	// controller side
	input wire logic        irq,
	input wire logic        mask,
	input wire logic [5:0]  vec,
	input wire logic [7:0]  fdata,
	output logic            mset,
	output logic            rd,
	output logic [15:0]     addr,
	// fetched routine address
	output logic            stb,
	output logic [15:0]     isr
);
	logic [15:0] a;
	initial begin
		mset = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		stb = 1'b0;
		isr = 16'h0000;
	end
	// one entry per pass; vector read only after it is latched
	always begin
		@(posedge clk);
		stb <= 1'b0;
		if (rst_b && irq && !mask) begin
			repeat (lag) @(posedge clk);
			mset <= 1'b1;
			@(posedge clk);
			mset <= 1'b0;
			@(posedge clk);
			a = (vec == 6'h20) ? 16'hFF9E : 16'hFFFE - {9'h000, vec, 1'b0};
			rd <= 1'b1;
			addr <= a;
			@(posedge clk);
			addr <= a + 16'h0001;
			@(posedge clk);
			isr[15:8] <= fdata;
			rd <= 1'b0;
			addr <= ~a; // released bus must not look valid
			@(posedge clk);
			isr[7:0] <= fdata;
			stb <= 1'b1;
		end
	end
endmodule : ivpl_core_model
`default_nettype wire

// >>> tb_interrupt_vector_priority_logic.sv
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_vector_priority_logic;
	logic        clk = 0, rst_b = 0, qs = 0, os = 0, am = 0, mclr = 0;
	logic [20:0] ev = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [3:0]  lag = 0;
	wire logic   irq, gm, awr, wrd, bv, arr, rv, fv, mset, rd, stb;
	wire logic [1:0]  bresp, rresp;
	wire logic [5:0]  vn;
	wire logic [7:0]  fd;
	wire logic [15:0] fa, isr;
	wire logic [31:0] rdat;
	logic [15:0] tbl [21];
	logic [33:0] qr [$], qb [$], qi [$];
	int          error_cnt = 0, total_checks = 0, cyc = 0, seed = 70;
	always #2 clk = ~clk;
	ivpl_top u_dut (.REF_CLK(clk), .RST_B(rst_b), .SRC_EVENT(ev),
		.QUARTER_SECOND_EVENT(qs), .ONE_SECOND_EVENT(os),
		.ALARM_MATCH_EVENT(am), .CORE_MASK_SET(mset), .CORE_MASK_CLR(mclr),
		.CORE_FETCH_RD(rd), .CORE_FETCH_ADDR(fa), .CORE_IRQ_REQ(irq),
		.GLOBAL_MASK(gm), .VECTOR_NUM(vn), .CORE_FETCH_DATA(fd),
		.CORE_FETCH_VALID(fv), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	ivpl_core_model u_core (.clk(clk), .rst_b(rst_b), .lag(lag), .irq(irq),
		.mask(gm), .vec(vn), .fdata(fd), .mset(mset), .rd(rd), .addr(fa),
		.stb(stb), .isr(isr));
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic conclude;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	// write: address and data offered together, each released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic ta, tw;
		ta = 0;
		tw = 0;
		qb.push_back({32'h0, r});
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awr && awv) begin
				ta = 1;
				awv <= 0;
			end
			if (wrd && wv) begin
				tw = 1;
				wv <= 0;
			end
		end
		do @(posedge clk); while (!bv);
		br <= 0;
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [11:0] a, input logic [33:0] e);
		qr.push_back(e);
		ara <= a;
		arv <= 1;
		rr <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		rr <= 0;
		@(posedge clk);
	endtask : axr
	// one service: expect routine address, then clear flags and unmask
	task automatic svc(input int k, input logic [22:0] c);
		qi.push_back({18'h0, tbl[k]});
		do @(posedge clk); while (!stb);
		axw(12'h008, {9'h0, c}, 2'h0);
		mclr <= 1;
		@(posedge clk);
		mclr <= 0;
	endtask : svc
	// result watcher and hang limit
	always @(posedge clk) begin
		if (bv && br)
			chk({32'h0, bresp}, qb.size() ? qb.pop_front() : '1);
		if (rv && rr)
			chk({rresp, rdat}, qr.size() ? qr.pop_front() : '1);
		if (stb)
			chk({18'h0, isr}, qi.size() ? qi.pop_front() : '1);
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		for (int k = 0; k < 21; k++) tbl[k] = 16'($random(seed));
		repeat (12) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		axr(12'h00C, 34'h1);
		axw(12'h020, 32'h1, 2'h2);
		for (int k = 0; k < 21; k++) axw(12'(256 + 4 * k), {16'h0, tbl[k]}, 2'h0);
		ev[0] <= 1;
		@(posedge clk);
		ev[0] <= 0;
		axr(12'h000, 34'h1);
		chk({33'h0, irq}, 34'h0);
		axw(12'h008, 32'h1, 2'h0);
		axw(12'h004, 32'h007FFFFF, 2'h0);
		axw(12'h00C, 32'h1, 2'h0);
		// two sources at once: smaller vector first
		ev <= 21'h000408;
		@(posedge clk);
		ev <= 21'h0;
		axr(12'h010, 34'h10F);
		svc(3, 23'h8);
		svc(10, 23'h400);
		// each time-of-day flag alone, random core pace
		for (int i = 0; i < 3; i++) begin
			lag <= 4'($random(seed));
			{am, os, qs} <= 3'(1 << i);
			@(posedge clk);
			{am, os, qs} <= 3'h0;
			svc(17, 23'h620000);
		end
		axr(12'h000, 34'h0);
		conclude();
	end
endmodule : tb_interrupt_vector_priority_logic
`default_nettype wire
